// File: aout_diag_defs.vh
// constants for the four-channel current-output range and diagnostic block
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`ifndef AOUT_DIAG_DEFS_VH
`define AOUT_DIAG_DEFS_VH

`define CODE_OFF          8'hff
`define CODE_4_20_WIDE    8'h30
`define CODE_0_20_WIDE    8'h31
`define CODE_4_20_NARROW  8'h40
`define CODE_0_20_NARROW  8'h41
`define CODE_DEFAULT      8'h31

`define PIDX_OPEN         8'h01
`define PIDX_RANGE0       8'h02

`define WIDE_FULL         17'h06c00
`define WIDE_OVER         17'sh07eff
`define WIDE_UNDER        17'sh1e500
`define WIDE_OFFSET       17'h01b00
`define NARROW_FULL       17'h04000
`define NARROW_OVER       17'sh05000
`define NARROW_UNDER      17'sh1f000
`define NARROW_OFFSET     17'h01000
`define DAC_SCALE         34'h000000ccc

`define SET_HEAD        8'h00
`define SET_FULL        8'h01
`define HEAD_LEN        5'h04
`define FULL_LEN        5'h14

`define MODULE_INFO     8'h15
`define CHANNEL_TYPE    8'h73
`define DIAG_BITS       8'h08
`define CHANNEL_COUNT   8'h04

`define SUM_FAIL        0
`define SUM_INTERNAL    1
`define SUM_EXTERNAL    2
`define SUM_CHANNEL     3
`define SUM_AUX         4
`define SUM_PARAM       7
`define INT_OVERFLOW    3
`define INT_COMM        4
`define CHF_PARAM       0
`define CHF_OPEN        4

`define IDX_SUMMARY     5'h00
`define IDX_MODINFO     5'h01
`define IDX_RES_C       5'h02
`define IDX_INTERNAL    5'h03
`define IDX_CHTYPE      5'h04
`define IDX_BITS        5'h05
`define IDX_COUNT       5'h06
`define IDX_GROUP       5'h07
`define IDX_CHAN0       5'h08
`define IDX_STAMP0      5'h10

`endif

// File: range_scaler.v
// converts one channel's signed output value to a 12-bit dac code by range
`timescale 1ns/1ps
`default_nettype none
`include "aout_diag_defs.vh"

module range_scaler #(
  parameter DAC_BITS = 12
) (
  input  wire                clk,
  input  wire                reset,
  input  wire [7:0]          channel_range_code,
  input  wire signed [15:0]  value,
  output reg  [DAC_BITS-1:0] dac_code,
  output reg                 enable,
  output reg                 code_error
);
  // dac full code corresponds to the highest overrange current of 25 mA;
  // the wide format puts 20 mA at 27648, the narrow one at 16384.
  reg signed [16:0] lim;
  reg        [16:0] span;
  reg        [16:0] off;
  reg        [33:0] prod;
  reg               valid;
  reg               narrow;
  reg               live_zero;

  always @* begin
    valid     = 1'b1;
    narrow    = 1'b0;
    live_zero = 1'b0;
    case (channel_range_code)
      `CODE_0_20_WIDE:   narrow = 1'b0;
      `CODE_0_20_NARROW: narrow = 1'b1;
      `CODE_4_20_WIDE:   live_zero = 1'b1;
      `CODE_4_20_NARROW: begin
        narrow    = 1'b1;
        live_zero = 1'b1;
      end
      default: valid = 1'b0;
    endcase
    // clamp to the permitted window of each range
    lim = {value[15], value};
    if (narrow && lim > `NARROW_OVER) lim = `NARROW_OVER;
    if (!narrow && lim > `WIDE_OVER) lim = `WIDE_OVER;
    if (!live_zero && lim < 17'sh00000) lim = 17'sh00000;
    if (live_zero && narrow && lim < `NARROW_UNDER) lim = `NARROW_UNDER;
    if (live_zero && !narrow && lim < `WIDE_UNDER) lim = `WIDE_UNDER;
    // shift 4..20 ranges up so 0 mA sits at zero: a quarter of full scale
    off  = live_zero ? (narrow ? `NARROW_OFFSET : `WIDE_OFFSET) : 17'h00000;
    // a live-zero range gives only 16 mA per full scale, so 20 mA spans 1.25 of it
    span = (narrow ? `NARROW_FULL : `WIDE_FULL) + off;
    // code = (v + off) * (20/25 of 4095) / span
    prod = ({17'h00000, lim[16:0] + off} * `DAC_SCALE) / {17'h00000, span};
  end

  always @(posedge clk) begin
    if (reset) begin
      dac_code   <= {DAC_BITS{1'b0}};
      enable     <= 1'b0;
      code_error <= 1'b0;
    end else begin
      enable     <= valid;
      code_error <= !valid && channel_range_code != `CODE_OFF;
      dac_code   <= valid ? prod[DAC_BITS-1:0] : {DAC_BITS{1'b0}};
    end
  end
endmodule // range_scaler

`default_nettype wire

// File: aout_diag.v
// four-channel current output range control and diagnostic record
`timescale 1ns/1ps
`default_nettype none
`include "aout_diag_defs.vh"

module aout_diag #(
  parameter NCH      = 4,
  parameter DAC_BITS = 12,
  parameter CLK_MHZ  = 25
) (
  input  wire                    clk,
  input  wire                    reset,
  input  wire                    param_write,
  input  wire [7:0]              param_index,
  input  wire [7:0]              param_data,
  input  wire                    value_write,
  input  wire [1:0]              value_channel,
  input  wire [15:0]             value_data,
  input  wire                    record_read,
  input  wire [7:0]              record_set,
  input  wire [4:0]              record_byte,
  output reg  [7:0]              record_data,
  output reg                     record_valid,
  input  wire [NCH-1:0]          open_load_pin,
  input  wire                    aux_supply_ok_pin,
  input  wire                    internal_comm_error,
  input  wire                    diag_overflow,
  output wire [NCH*DAC_BITS-1:0] dac_codes,
  output wire [NCH-1:0]          channel_enable,
  output reg  [NCH-1:0]          channel_error_led,
  output reg                     group_error_led
);
  // ------------------------------------------------------------------
  // parameter record: index 0 reserved, 1 open-load enables, 2..5 range codes
  // ------------------------------------------------------------------
  reg  [7:0]  channel_range_code [0:NCH-1];
  reg  [3:0]  open_load_detect_enable;
  reg  [15:0] out_value [0:NCH-1];
  wire [NCH-1:0] code_error;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      always @(posedge clk) begin
        if (reset) begin
          channel_range_code[g] <= `CODE_DEFAULT;
          out_value[g]          <= 16'h0000;
        end else begin
          if (param_write && param_index == `PIDX_RANGE0 + g)
            channel_range_code[g] <= param_data;
          if (value_write && value_channel == g)
            out_value[g] <= value_data;
        end
      end
      range_scaler #(.DAC_BITS(DAC_BITS)) scaler (
        .clk                (clk),
        .reset              (reset),
        .channel_range_code (channel_range_code[g]),
        .value              (out_value[g]),
        .dac_code           (dac_codes[g*DAC_BITS +: DAC_BITS]),
        .enable             (channel_enable[g]),
        .code_error         (code_error[g])
      );
    end
  endgenerate

  always @(posedge clk) begin
    if (reset)
      open_load_detect_enable <= 4'h0;
    else if (param_write && param_index == `PIDX_OPEN)
      open_load_detect_enable <= param_data[3:0];
  end

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  reg [NCH-1:0] open_meta;
  reg [NCH-1:0] open_sync;
  reg [1:0]     aux_meta;
  reg [1:0]     aux_sync;

  always @(posedge clk) begin
    if (reset) begin
      open_meta <= {NCH{1'b0}};
      open_sync <= {NCH{1'b0}};
      aux_meta  <= 2'b11;
      aux_sync  <= 2'b11;
    end else begin
      open_meta <= open_load_pin;
      open_sync <= open_meta;
      aux_meta  <= {aux_meta[0], aux_supply_ok_pin};
      aux_sync  <= {aux_sync[0], aux_meta[1]};
    end
  end

  // ------------------------------------------------------------------
  // microsecond ticker
  // ------------------------------------------------------------------
  reg [7:0]  us_div;
  reg [31:0] us_count;

  always @(posedge clk) begin
    if (reset) begin
      us_div   <= 8'h00;
      us_count <= 32'h00000000;
    end else if (us_div == CLK_MHZ - 1) begin
      us_div   <= 8'h00;
      us_count <= us_count + 32'h00000001;
    end else begin
      us_div <= us_div + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // diagnostic state: levels follow the live condition
  // ------------------------------------------------------------------
  reg  [7:0] chan_fault [0:NCH-1];
  reg  [7:0] diag_summary;
  reg  [7:0] diag_internal;
  reg  [7:0] channel_group_errors;
  reg  [31:0] diag_timestamp;
  reg  [7:0] next_summary;
  reg  [7:0] next_internal;
  reg  [NCH-1:0] next_group;
  reg  [7:0] next_fault [0:NCH-1];
  reg        any_param;
  integer    i;

  always @* begin
    any_param = 1'b0;
    next_group = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      next_fault[i] = 8'h00;
      next_fault[i][`CHF_PARAM] = code_error[i];
      next_fault[i][`CHF_OPEN]  = open_sync[i] && open_load_detect_enable[i]
                                  && channel_enable[i];
      next_group[i] = |next_fault[i];
      any_param = any_param | code_error[i];
    end
    next_internal = 8'h00;
    next_internal[`INT_OVERFLOW] = diag_overflow;
    next_internal[`INT_COMM]     = internal_comm_error;
    next_summary = 8'h00;
    next_summary[`SUM_INTERNAL] = |next_internal;
    next_summary[`SUM_EXTERNAL] = |next_group || !aux_sync[1];
    next_summary[`SUM_CHANNEL]  = |next_group;
    next_summary[`SUM_AUX]      = !aux_sync[1];
    next_summary[`SUM_PARAM]    = any_param;
    next_summary[`SUM_FAIL]     = !aux_sync[1] || internal_comm_error;
  end

  // a summary bit or a channel group bit newly set is a diagnostic event
  wire event_now = |((next_summary | diag_summary) ^ diag_summary) ||
                   |(next_group & ~channel_group_errors[NCH-1:0]);

  always @(posedge clk) begin
    if (reset) begin
      diag_summary         <= 8'h00;
      diag_internal        <= 8'h00;
      channel_group_errors <= 8'h00;
      diag_timestamp       <= 32'h00000000;
      channel_error_led    <= {NCH{1'b0}};
      group_error_led      <= 1'b0;
    end else begin
      diag_summary         <= next_summary;
      diag_internal        <= next_internal;
      channel_group_errors <= {{(8-NCH){1'b0}}, next_group};
      channel_error_led    <= next_group;
      group_error_led      <= |next_summary;
      if (event_now)
        diag_timestamp <= us_count;
    end
  end

  generate
    for (g = 0; g < NCH; g = g + 1) begin : faults
      always @(posedge clk) begin
        if (reset)
          chan_fault[g] <= 8'h00;
        else
          chan_fault[g] <= next_fault[g];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // record read port: no interrupt, the controller polls
  // ------------------------------------------------------------------
  reg [7:0] byte_mux;

  always @* begin
    case (record_byte)
      `IDX_SUMMARY:  byte_mux = diag_summary;
      `IDX_MODINFO:  byte_mux = `MODULE_INFO;
      `IDX_RES_C:    byte_mux = 8'h00;
      `IDX_INTERNAL: byte_mux = diag_internal;
      `IDX_CHTYPE:   byte_mux = `CHANNEL_TYPE;
      `IDX_BITS:     byte_mux = `DIAG_BITS;
      `IDX_COUNT:    byte_mux = `CHANNEL_COUNT;
      `IDX_GROUP:    byte_mux = channel_group_errors;
      5'h08:         byte_mux = chan_fault[0];
      5'h09:         byte_mux = chan_fault[1];
      5'h0a:         byte_mux = chan_fault[2];
      5'h0b:         byte_mux = chan_fault[3];
      5'h10:         byte_mux = diag_timestamp[7:0];
      5'h11:         byte_mux = diag_timestamp[15:8];
      5'h12:         byte_mux = diag_timestamp[23:16];
      5'h13:         byte_mux = diag_timestamp[31:24];
      default:       byte_mux = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      record_data  <= 8'h00;
      record_valid <= 1'b0;
    end else begin
      record_valid <= record_read;
      // out-of-range bytes and unknown sets read as zero
      if (record_read && ((record_set == `SET_FULL && record_byte < `FULL_LEN) ||
                          (record_set == `SET_HEAD && record_byte < `HEAD_LEN)))
        record_data <= byte_mux;
      else
        record_data <= 8'h00;
    end
  end
endmodule // aout_diag

`default_nettype wire

// File: aout_diag_sva.sv
// assertions on the ports of the current output diagnostic block
`timescale 1ns/1ps
`default_nettype none
module aout_diag_sva #(
  parameter NCH = 4
) (
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           param_write,
  input wire logic [7:0]     param_index,
  input wire logic [7:0]     param_data,
  input wire logic           record_read,
  input wire logic [7:0]     record_set,
  input wire logic [4:0]     record_byte,
  input wire logic [7:0]     record_data,
  input wire logic           record_valid,
  input wire logic [NCH-1:0] channel_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire full = record_read && record_set == 8'h01;
  property p_answer; record_read |=> record_valid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_no_spurious; record_valid |-> $past(record_read); endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
  property p_head; record_read && record_set == 8'h00 && record_byte > 5'h03
    |=> record_data == 8'h00; endproperty
  a_head: assert property (p_head) else $error("short set gave data");
  property p_modinfo; full && record_byte == 5'h01 |=> record_data == 8'h15; endproperty
  a_modinfo: assert property (p_modinfo) else $error("module info wrong");
  property p_bits; full && record_byte == 5'h05 |=> record_data == 8'h08; endproperty
  a_bits: assert property (p_bits) else $error("bit count wrong");
  property p_count; full && record_byte == 5'h06 |=> record_data == 8'h04; endproperty
  a_count: assert property (p_count) else $error("channel count wrong");
  property p_group; full && record_byte == 5'h07 |=> record_data[7:4] == 4'h0; endproperty
  a_group: assert property (p_group) else $error("group high bits set");
  property p_off; param_write && param_index == 8'h02 && param_data == 8'hff
    |-> ##2 channel_enable[0] == 1'b0; endproperty
  a_off: assert property (p_off) else $error("channel not disabled");
endmodule // aout_diag_sva

bind aout_diag aout_diag_sva #(.NCH(NCH)) aout_diag_sva_i (.clk, .reset, .param_write,
  .param_index, .param_data, .record_read, .record_set, .record_byte, .record_data,
  .record_valid, .channel_enable);
`default_nettype wire

// File: bus_coupler_model.sv
// bus coupler model: writes parameters and values, fetches diagnostic bytes
`timescale 1ns/1ps
`default_nettype none
module bus_coupler_model (
  input  wire logic        clk,
  input  wire logic        record_valid,
  input  wire logic [7:0]  record_data,
  output var  logic        record_read,
  output var  logic [7:0]  record_set,
  output var  logic [4:0]  record_byte,
  output var  logic        param_write,
  output var  logic [7:0]  param_index,
  output var  logic [7:0]  param_data,
  output var  logic        value_write,
  output var  logic [1:0]  value_channel,
  output var  logic [15:0] value_data
);
  initial begin
    {record_read, record_set, record_byte, param_write, param_index} = 23'h0;
    {param_data, value_write, value_channel, value_data} = 27'h0;
  end
  // released lines except param_index and value_channel show the inverse so a stale value never looks valid
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    param_write <= 1'b1;
    param_index <= idx;
    param_data <= d;
    @(posedge clk);
    param_write <= 1'b0;
    param_data <= ~d;
  endtask
  task automatic load(input logic [1:0] ch, input logic [15:0] v);
    @(posedge clk);
    value_write <= 1'b1;
    value_channel <= ch;
    value_data <= v;
    @(posedge clk);
    value_write <= 1'b0;
    value_data <= ~v;
  endtask
  task automatic fetch(input logic [7:0] set, input logic [4:0] idx,
                       output logic ok, output logic [7:0] d);
    @(posedge clk);
    record_read <= 1'b1;
    record_set <= set;
    record_byte <= idx;
    @(posedge clk);
    record_read <= 1'b0;
    record_set <= ~set;
    record_byte <= ~idx;
    @(negedge clk);
    ok = record_valid;
    d = record_data;
  endtask
endmodule // bus_coupler_model
`default_nettype wire

// File: test_aout_diag.sv
// self-checking bench for the current output range and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module test_aout_diag;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] open_load_pin = 4'h0;
  logic aux_supply_ok_pin = 1'b1;
  logic internal_comm_error = 1'b0;
  logic diag_overflow = 1'b0;
  wire record_read, record_valid, param_write, value_write, group_error_led;
  wire [7:0] record_set, record_data, param_index, param_data;
  wire [4:0] record_byte;
  wire [1:0] value_channel;
  wire [15:0] value_data;
  wire [47:0] dac_codes;
  wire [3:0] channel_enable, channel_error_led;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  logic ok;
  logic [7:0] d;
  logic [31:0] t0, t1;
  // want: dac code with 25 mA at full scale; live-zero ranges give 16 mA per full scale
  typedef struct {logic [1:0] ch; logic [7:0] code; int v; int want;} row_t;
  row_t rows[12] = '{'{0,8'h31,27648,3276}, '{1,8'h31,32767,3852}, '{2,8'h31,-100,0},
    '{3,8'h41,16384,3276}, '{0,8'h41,20480,4095}, '{1,8'h41,-1,0}, '{2,8'h30,0,655},
    '{3,8'h30,-8000,0}, '{0,8'h30,27648,3276}, '{1,8'h40,-4096,0},
    '{2,8'h40,20480,3931}, '{3,8'h30,32511,3736}};
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= reset ? 0 : cyc + 1;
  aout_diag aout_diag_i (.clk, .reset, .param_write, .param_index, .param_data,
    .value_write, .value_channel, .value_data, .record_read, .record_set, .record_byte,
    .record_data, .record_valid, .open_load_pin, .aux_supply_ok_pin, .internal_comm_error,
    .diag_overflow, .dac_codes, .channel_enable, .channel_error_led, .group_error_led);
  bus_coupler_model bus_coupler_model_i (.clk, .record_valid, .record_data, .record_read,
    .record_set, .record_byte, .param_write, .param_index, .param_data, .value_write,
    .value_channel, .value_data);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] idx, input logic [7:0] want, input logic [7:0] set = 1);
    bus_coupler_model_i.fetch(set, idx, ok, d);
    check(ok, 1);
    check(d, want);
  endtask
  task automatic stamp(output logic [31:0] s);
    for (int k = 0; k < 4; k++) begin
      bus_coupler_model_i.fetch(8'h01, 5'd16 + k[4:0], ok, s[8*k +: 8]);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      rd(i, i == 1 ? 8'h15 : i == 4 ? 8'h73 : i == 5 ? 8'h08 : i == 6 ? 8'h04 : 8'h00);
    end
    $display("defaults done");
    foreach (rows[i]) begin
      bus_coupler_model_i.put(8'h02 + rows[i].ch, rows[i].code);
      bus_coupler_model_i.load(rows[i].ch, rows[i].v[15:0]);
      settle(3);
      check(channel_enable[rows[i].ch], 1);
      check(dac_codes[rows[i].ch*12 +: 12], rows[i].want);
    end
    $display("ranges done");
    bus_coupler_model_i.put(8'h02, 8'hff);
    settle(3);
    check(channel_enable[0], 0);
    rd(0, 8'h00);
    bus_coupler_model_i.put(8'h03, 8'h22);
    t0 = cyc;
    settle(4);
    check({channel_error_led[1], channel_enable[1], group_error_led}, 3'b101);
    rd(0, 8'h8c);
    rd(7, 8'h02);
    rd(9, 8'h01);
    stamp(t1);
    check(t1 + 1 >= t0 / 25 && t1 <= t0 / 25 + 2, 1);
    settle(50);
    stamp(t0);
    check(t0, t1);
    bus_coupler_model_i.put(8'h03, 8'h31);
    settle(4);
    rd(0, 8'h00);
    $display("parameter error done");
    bus_coupler_model_i.put(8'h01, 8'h04);
    @(posedge clk) open_load_pin <= 4'h6;
    settle(6);
    rd(10, 8'h10);
    rd(9, 8'h00);
    rd(7, 8'h04);
    bus_coupler_model_i.put(8'h01, 8'h00);
    settle(4);
    rd(10, 8'h00);
    @(posedge clk) open_load_pin <= 4'h0;
    aux_supply_ok_pin <= 1'b0;
    settle(6);
    rd(0, 8'h15);
    @(posedge clk) aux_supply_ok_pin <= 1'b1;
    diag_overflow <= 1'b1;
    settle(6);
    rd(3, 8'h08);
    rd(0, 8'h02);
    @(posedge clk) diag_overflow <= 1'b0;
    internal_comm_error <= 1'b1;
    settle(4);
    rd(3, 8'h10);
    rd(0, 8'h03);
    @(posedge clk) internal_comm_error <= 1'b0;
    $display("faults done");
    rd(4, 8'h00, 8'h00);
    rd(1, 8'h15, 8'h00);
    rd(1, 8'h00, 8'h02);
    rd(20, 8'h00);
    bus_coupler_model_i.put(8'h02, 8'hff);
    @(posedge clk) reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    settle(2);
    check(channel_enable, 4'hf);
    $display("refusal and reset done");
    stop_test();
  end
endmodule // test_aout_diag
`default_nettype wire
